// >>> design/ivm_top.sv
`timescale 1ns/10ps
`default_nettype none
module ivm_top (
  input  wire logic                        clk_i,
  input  wire logic                        rstn_i,
  input  wire logic [ivm_pkg::NUM_VEC-1:0] irq_event_i,
  input  wire logic [ivm_pkg::NUM_VEC-1:0] irq_flag_clr_i,
  input  wire logic [ivm_pkg::NUM_VEC-1:0] irq_enable_wr_i,
  input  wire logic [ivm_pkg::NUM_VEC-1:0] irq_enable_wdata_i,
  input  wire logic                        global_irq_en_i,
  input  wire logic                        big_prog_mem_i,
  input  wire logic [7:0]                  part_rev_strap_i,
  input  wire logic [15:0]                 core_addr_i,
  input  wire logic                        core_rd_i,
  input  wire logic                        core_wr_i,
  output logic [ivm_pkg::NUM_VEC-1:0]      irq_flag_reg_o,
  output logic [ivm_pkg::NUM_VEC-1:0]      irq_enable_reg_o,
  output logic [ivm_pkg::NUM_VEC-1:0]      irq_req_o,
  output logic                             core_irq_o,
  output logic [5:0]                       core_vec_num_o,
  output logic [6:0]                       core_vec_addr_o,
  output ivm_pkg::ivm_sel_type             core_sel_o,
  output logic [2:0]                       core_vport_idx_o,
  output logic [7:0]                       core_rdata_o,
  output logic                             core_rvalid_o
);
  import ivm_pkg::*;

  // ---------------------------------------------------------------
  // flags and enables
  // ---------------------------------------------------------------
  logic [NUM_VEC-1:0] irq_flag_reg_r, irq_flag_reg_nxt;
  logic [NUM_VEC-1:0] irq_enable_reg_r, irq_enable_reg_nxt;
  logic [NUM_VEC-1:0] req_w;

  // vector 0 is the reset entry: never a flag source
  generate
    for (genvar g = 0; g < NUM_VEC; g++) begin : g_src
      always_comb begin
        if (g == 0) begin
          irq_flag_reg_nxt[g]   = 1'b0;
          irq_enable_reg_nxt[g] = 1'b0;
        end else begin
          // set beats clear in the same cycle
          irq_flag_reg_nxt[g] = irq_event_i[g] | (irq_flag_reg_r[g] & ~irq_flag_clr_i[g]);
          irq_enable_reg_nxt[g] = irq_enable_wr_i[g] ? irq_enable_wdata_i[g]
                                                     : irq_enable_reg_r[g];
        end
      end
      // crc-scan nmi ignores enables and the global enable
      assign req_w[g] = (g == 1) ? irq_flag_reg_r[g]
                                 : (irq_flag_reg_r[g] & irq_enable_reg_r[g] & global_irq_en_i);
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_flag_reg_r   <= '0;
      irq_enable_reg_r <= '0;
    end else begin
      irq_flag_reg_r   <= irq_flag_reg_nxt;
      irq_enable_reg_r <= irq_enable_reg_nxt;
    end
  end

  assign irq_flag_reg_o   = irq_flag_reg_r;
  assign irq_enable_reg_o = irq_enable_reg_r;
  assign irq_req_o        = req_w;

  // ---------------------------------------------------------------
  // vector selection
  // ---------------------------------------------------------------
  // source index equals vector number, so the table order is the
  // wiring order of irq_event_i
  ivm_req_if arb_bus ();
  assign arb_bus.req = req_w;
  ivm_prio_arb u_arb (
    .port_a (arb_bus)
  );

  logic [5:0] vec_num_r, vec_num_nxt;
  logic [6:0] vec_addr_r, vec_addr_nxt;
  logic       core_irq_r, core_irq_nxt;

  always_comb begin
    core_irq_nxt = arb_bus.valid;
    vec_num_nxt  = arb_bus.vec_num;
    // program memory above 8 KB uses two-word vector slots
    vec_addr_nxt = big_prog_mem_i ? {arb_bus.vec_num, 1'b0}
                                  : {1'b0, arb_bus.vec_num};
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      core_irq_r <= 1'b0;
      vec_num_r  <= 6'h00;
      vec_addr_r <= 7'h00;
    end else begin
      core_irq_r <= core_irq_nxt;
      vec_num_r  <= vec_num_nxt;
      vec_addr_r <= vec_addr_nxt;
    end
  end

  assign core_irq_o      = core_irq_r;
  assign core_vec_num_o  = vec_num_r;
  assign core_vec_addr_o = vec_addr_r;

  // ---------------------------------------------------------------
  // address decode and revision register
  // ---------------------------------------------------------------
  ivm_sel_type sel_w;
  logic [2:0]  vport_idx_w;

  ivm_addr_dec u_dec (
    .addr_i      (core_addr_i),
    .sel_o       (sel_w),
    .vport_idx_o (vport_idx_w)
  );

  assign core_sel_o       = sel_w;
  assign core_vport_idx_o = vport_idx_w;

  // strap caught on the first clock after reset release
  logic [7:0] part_revision_r, part_revision_nxt;
  logic       rev_loaded_r, rev_loaded_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       rvalid_r, rvalid_nxt;

  always_comb begin
    rev_loaded_nxt    = 1'b1;
    // core writes never touch the revision
    part_revision_nxt = rev_loaded_r ? part_revision_r : part_rev_strap_i;
    rvalid_nxt        = core_rd_i;
    rdata_nxt         = 8'h00;
    if (core_rd_i && core_addr_i == BASE_SYS_CONFIG + OFS_PART_REV) begin
      rdata_nxt = part_revision_r;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      part_revision_r <= PART_REV_DEFAULT;
      rev_loaded_r    <= 1'b0;
      rdata_r         <= 8'h00;
      rvalid_r        <= 1'b0;
    end else begin
      part_revision_r <= part_revision_nxt;
      rev_loaded_r    <= rev_loaded_nxt;
      rdata_r         <= rdata_nxt;
      rvalid_r        <= rvalid_nxt;
    end
  end

  assign core_rdata_o  = rdata_r;
  assign core_rvalid_o = rvalid_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  flag_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_event_i[5] |=> irq_flag_reg_o[5])
    else $error("event did not set flag");
  flag_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_flag_reg_o[9] && !irq_flag_clr_i[9] |=> irq_flag_reg_o[9])
    else $error("flag dropped");
  req_and_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_req_o[7] == (irq_flag_reg_o[7] && irq_enable_reg_o[7] && global_irq_en_i))
    else $error("req mismatch");
  enable_wr_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_enable_wr_i[3] |=> irq_enable_reg_o[3] == $past(irq_enable_wdata_i[3]))
    else $error("enable write lost");
  global_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !global_irq_en_i |-> (irq_req_o & ~40'h00_0000_0002) == '0)
    else $error("req without global enable");
  nmi_bypass_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_flag_reg_o[VEC_NMI_CRC] |-> irq_req_o[VEC_NMI_CRC])
    else $error("nmi request missing");
  reset_vec_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !irq_flag_reg_o[VEC_RESET] && !irq_req_o[VEC_RESET])
    else $error("reset vector raised");
  vec_addr_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    core_irq_o |-> core_vec_addr_o == ($past(big_prog_mem_i) ? 7'(core_vec_num_o) * 7'h02
                                                            : 7'(core_vec_num_o)))
    else $error("bad vector address");
  last_vec_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    core_irq_o && core_vec_num_o == VEC_LAST |->
      core_vec_addr_o == ($past(big_prog_mem_i) ? VEC_LAST_ADDR_L : VEC_LAST_ADDR_S))
    else $error("bad last vector address");
  lowest_vec_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_req_o[2] |=> core_irq_o && core_vec_num_o <= 6'h02)
    else $error("not lowest vector");
  timer_vec_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_req_o[VEC_PERIOD_TMR] && irq_req_o[VEC_PERIOD_TMR-1:0] == '0 |=> core_vec_num_o == VEC_PERIOD_TMR)
    else $error("periodic timer vector");
  tmra_vec_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_req_o[VEC_TMRA_OVF] && irq_req_o[VEC_TMRA_OVF-1:0] == '0 |=> core_vec_num_o == VEC_TMRA_OVF)
    else $error("type-a timer vector");
  ser_vec_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_req_o[VEC_SER0_RXC] && irq_req_o[VEC_SER0_RXC-1:0] == '0 |=> core_vec_num_o == VEC_SER0_RXC)
    else $error("serial port vector");
  pin_vec_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_req_o[VEC_PORT_D] && irq_req_o[VEC_PORT_D-1:0] == '0 |=> core_vec_num_o == VEC_PORT_D)
    else $error("pin-change vector");
  conv_vec_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_req_o[VEC_CONV_RESRDY] && irq_req_o[VEC_CONV_RESRDY-1:0] == '0 |=> core_vec_num_o == VEC_CONV_RESRDY)
    else $error("converter vector");
  spi_vec_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_req_o[VEC_SPP] && irq_req_o[VEC_SPP-1:0] == '0 |=> core_vec_num_o == VEC_SPP)
    else $error("spi vector");
  rev_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    core_rd_i && core_addr_i == ADDR_PART_REV |=> core_rdata_o == $past(part_revision_r))
    else $error("bad revision read");
  rev_ro_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rev_loaded_r |=> $stable(part_revision_r))
    else $error("revision changed");
  rev_wr_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    core_wr_i && core_addr_i == ADDR_PART_REV && rev_loaded_r |=> $stable(part_revision_r))
    else $error("revision written");
  wdog_dec_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    core_addr_i == BASE_WDOG |-> core_sel_o == IVM_SEL_WDOG)
    else $error("watchdog decode");
  core_dec_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    core_addr_i == BASE_CORE |-> core_sel_o == IVM_SEL_CORE)
    else $error("core decode");
  user_row_dec_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    core_addr_i == BASE_USER_ROW |-> core_sel_o == IVM_SEL_USER_ROW)
    else $error("user row decode");
  gpr_dec_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    core_addr_i == BASE_GPR |-> core_sel_o == IVM_SEL_GPR)
    else $error("gpr decode");
  vport_dec_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    core_sel_o == IVM_SEL_VPORT |-> core_vport_idx_o == core_addr_i[4:2])
    else $error("virtual port index");
  sys_cfg_dec_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    core_addr_i == ADDR_PART_REV |-> core_sel_o == IVM_SEL_SYS_CONFIG)
    else $error("system config decode");
endmodule // ivm_top
`default_nettype wire

// >>> design/ivm_pkg.sv
package ivm_pkg;
  // ---------------------------------------------------------------
  // vector table
  // ---------------------------------------------------------------
  localparam int          NUM_VEC          = 40;
  localparam logic [5:0]  VEC_RESET        = 6'h00;
  localparam logic [5:0]  VEC_NMI_CRC      = 6'h01;
  localparam logic [5:0]  VEC_VOLT_MON     = 6'h02;
  localparam logic [5:0]  VEC_RTC          = 6'h03;
  localparam logic [5:0]  VEC_PERIOD_TMR   = 6'h04;
  localparam logic [5:0]  VEC_CLU          = 6'h05;
  localparam logic [5:0]  VEC_PORT_A       = 6'h06;
  localparam logic [5:0]  VEC_TMRA_OVF     = 6'h07;
  localparam logic [5:0]  VEC_TMRA_UNF     = 6'h08;
  localparam logic [5:0]  VEC_TMRA_CMP0    = 6'h09;
  localparam logic [5:0]  VEC_TMRA_CMP2    = 6'h0B;
  localparam logic [5:0]  VEC_TMRB0_CAPT   = 6'h0C;
  localparam logic [5:0]  VEC_TMRB1_CAPT   = 6'h0D;
  localparam logic [5:0]  VEC_TWP_SLAVE    = 6'h0E;
  localparam logic [5:0]  VEC_TWP_MASTER   = 6'h0F;
  localparam logic [5:0]  VEC_SPP          = 6'h10;
  localparam logic [5:0]  VEC_SER0_RXC     = 6'h11;
  localparam logic [5:0]  VEC_SER0_TXC     = 6'h13;
  localparam logic [5:0]  VEC_PORT_D       = 6'h14;
  localparam logic [5:0]  VEC_ACMP         = 6'h15;
  localparam logic [5:0]  VEC_CONV_RESRDY  = 6'h16;
  localparam logic [5:0]  VEC_CONV_WCMP    = 6'h17;
  localparam logic [5:0]  VEC_PORT_C       = 6'h18;
  localparam logic [5:0]  VEC_TMRB2_CAPT   = 6'h19;
  localparam logic [5:0]  VEC_PORT_F       = 6'h1D;
  localparam logic [5:0]  VEC_NONVOL_READY = 6'h1E;
  localparam logic [5:0]  VEC_PORT_B       = 6'h22;
  localparam logic [5:0]  VEC_PORT_E       = 6'h23;
  localparam logic [5:0]  VEC_TMRB3_CAPT   = 6'h24;
  localparam logic [5:0]  VEC_LAST         = 6'h27;
  localparam logic [6:0]  VEC_LAST_ADDR_S  = 7'h27;
  localparam logic [6:0]  VEC_LAST_ADDR_L  = 7'h4E;

  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam logic [15:0] BASE_VPORT       = 16'h0000;
  localparam logic [15:0] VPORT_STRIDE     = 16'h0004;
  localparam logic [15:0] BASE_GPR         = 16'h001C;
  localparam logic [15:0] BASE_CORE        = 16'h0030;
  localparam logic [15:0] BASE_RSTCTL      = 16'h0040;
  localparam logic [15:0] BASE_WDOG        = 16'h0100;
  localparam logic [15:0] BASE_SYS_CONFIG  = 16'h0F00;
  localparam logic [15:0] BASE_USER_ROW    = 16'h1300;
  localparam logic [15:0] OFS_PART_REV     = 16'h0001;
  localparam logic [15:0] ADDR_PART_REV    = 16'h0F01;
  localparam logic [7:0]  PART_REV_DEFAULT = 8'h00; // arbitrary value

  typedef enum logic [3:0] {
    IVM_SEL_NONE, IVM_SEL_VPORT, IVM_SEL_GPR, IVM_SEL_CORE, IVM_SEL_RSTCTL,
    IVM_SEL_WDOG, IVM_SEL_SYS_CONFIG, IVM_SEL_USER_ROW
  } ivm_sel_type;
endpackage : ivm_pkg

// >>> design/ivm_req_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ivm_req_if;
  logic [ivm_pkg::NUM_VEC-1:0] req;
  logic                        valid;
  logic [5:0]                  vec_num;
  modport src (output req, input valid, input vec_num);
  modport arb (input req, output valid, output vec_num);
endinterface : ivm_req_if
`default_nettype wire

// >>> design/ivm_prio_arb.sv
`timescale 1ns/10ps
`default_nettype none
module ivm_prio_arb (
  ivm_req_if.arb port_a
);
  import ivm_pkg::*;
  // lowest index wins
  always_comb begin
    port_a.valid   = 1'b0;
    port_a.vec_num = 6'h00;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (port_a.req[i]) begin
        port_a.valid   = 1'b1;
        port_a.vec_num = 6'(i);
      end
    end
  end
endmodule // ivm_prio_arb
`default_nettype wire

// >>> design/ivm_addr_dec.sv
`timescale 1ns/10ps
`default_nettype none
module ivm_addr_dec (
  input  wire logic [15:0]          addr_i,
  output ivm_pkg::ivm_sel_type      sel_o,
  output logic [2:0]                vport_idx_o
);
  import ivm_pkg::*;
  always_comb begin
    sel_o       = IVM_SEL_NONE;
    vport_idx_o = 3'h0;
    if (addr_i < 16'h0018) begin
      sel_o       = IVM_SEL_VPORT;
      vport_idx_o = 3'(addr_i / VPORT_STRIDE);
    end else if (addr_i >= BASE_GPR && addr_i < BASE_GPR + 16'h0004) begin
      sel_o = IVM_SEL_GPR;
    end else if (addr_i >= BASE_CORE && addr_i < BASE_RSTCTL) begin
      sel_o = IVM_SEL_CORE;
    end else if (addr_i >= BASE_RSTCTL && addr_i < BASE_RSTCTL + 16'h0010) begin
      sel_o = IVM_SEL_RSTCTL;
    end else if (addr_i >= BASE_WDOG && addr_i < BASE_WDOG + 16'h0010) begin
      sel_o = IVM_SEL_WDOG;
    end else if (addr_i >= BASE_SYS_CONFIG && addr_i < BASE_SYS_CONFIG + 16'h0100) begin
      sel_o = IVM_SEL_SYS_CONFIG;
    end else if (addr_i >= BASE_USER_ROW && addr_i < BASE_USER_ROW + 16'h0040) begin
      sel_o = IVM_SEL_USER_ROW;
    end
  end
endmodule // ivm_addr_dec
`default_nettype wire

// >>> tb/ivm_periph_model.sv
`timescale 1ns/10ps
`default_nettype none
module ivm_periph_model (
  input  wire logic                        clk_i,
  output logic [ivm_pkg::NUM_VEC-1:0]      event_o,
  output logic [ivm_pkg::NUM_VEC-1:0]      clr_o
);
  import ivm_pkg::*;
  initial begin
    event_o = '0;
    clr_o   = '0;
  end
  // ---------------------------------------------------------------
  // peripheral strobes, one cycle each
  // ---------------------------------------------------------------
  // an event is a single-cycle condition; the flag must catch it
  task automatic pulse(input logic [NUM_VEC-1:0] ev);
    @(posedge clk_i);
    event_o <= ev;
    @(posedge clk_i);
    event_o <= '0;
    #1;
  endtask
  // software clearing the flag, as a peripheral flag write would
  task automatic clear(input logic [NUM_VEC-1:0] m);
    @(posedge clk_i);
    clr_o <= m;
    @(posedge clk_i);
    clr_o <= '0;
    #1;
  endtask
endmodule // ivm_periph_model
`default_nettype wire

// >>> tb/irq_vector_and_address_map_tb.sv
`timescale 1ns/10ps
`default_nettype none
module irq_vector_and_address_map_tb;
  import ivm_pkg::*;
  logic              clk_i, rstn_i, gie, big, rd, wr;
  logic [39:0]       ev, clr, en_wr, en_wd, flag, en_q, req;
  logic [15:0]       addr;
  logic              cirq, rvalid;
  logic [5:0]        vnum;
  logic [6:0]        vaddr;
  logic [2:0]        vidx;
  logic [7:0]        rdata;
  ivm_sel_type       sel;
  int                errors, checks_done;
  localparam logic [7:0]  REV = 8'hA5;
  localparam logic [15:0] DA [9] = '{16'h0000, 16'h0014, 16'h001C, 16'h0030, 16'h0040,
                                     16'h0100, 16'h0F01, 16'h1300, 16'h2000};
  localparam ivm_sel_type DS [9] = '{IVM_SEL_VPORT, IVM_SEL_VPORT, IVM_SEL_GPR, IVM_SEL_CORE,
                                     IVM_SEL_RSTCTL, IVM_SEL_WDOG, IVM_SEL_SYS_CONFIG,
                                     IVM_SEL_USER_ROW, IVM_SEL_NONE};

  ivm_periph_model ivm_periph_model_inst (.clk_i(clk_i), .event_o(ev), .clr_o(clr));
  ivm_top ivm_top_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .irq_event_i(ev), .irq_flag_clr_i(clr),
    .irq_enable_wr_i(en_wr), .irq_enable_wdata_i(en_wd), .global_irq_en_i(gie),
    .big_prog_mem_i(big), .part_rev_strap_i(REV), .core_addr_i(addr), .core_rd_i(rd),
    .core_wr_i(wr), .irq_flag_reg_o(flag), .irq_enable_reg_o(en_q), .irq_req_o(req),
    .core_irq_o(cirq), .core_vec_num_o(vnum), .core_vec_addr_o(vaddr), .core_sel_o(sel),
    .core_vport_idx_o(vidx), .core_rdata_o(rdata), .core_rvalid_o(rvalid));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic cmp(input string what, input logic [39:0] exp, input logic [39:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic set_en(input logic [39:0] m);
    @(posedge clk_i);
    en_wr <= '1;
    en_wd <= m;
    @(posedge clk_i);
    en_wr <= '0;
    #1;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    cmp("rvalid", 1, rvalid);
    cmp("rdata", exp, rdata);
  endtask
  task automatic end_sim;
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_walk_hold;
    set_en('1);
    cmp("en_q", 40'hFF_FFFF_FFFE, en_q);
    ivm_periph_model_inst.pulse(40'h1 << 9);
    cmp("flag9", 1, flag[9]);
    cmp("req9", 1, req[9]);
    tick(1);
    cmp("cirq", 1, cirq);
    cmp("vaddr_small", 7'h09, vaddr);
    @(posedge clk_i);
    big <= 1'b1;
    tick(5);
    cmp("vaddr_big", 7'h12, vaddr);
    cmp("req9_held", 1, req[9]);
    set_en(~(40'h1 << 9));
    cmp("req9_disabled", 0, req[9]);
    ivm_periph_model_inst.clear('1);
    set_en('1);
    cmp("flag_cleared", 0, flag);
  endtask
  task automatic t_global;
    @(posedge clk_i);
    gie <= 1'b0;
    ivm_periph_model_inst.pulse(40'h22);
    cmp("req5_gated", 0, req[5]);
    cmp("req1_nmi", 1, req[1]);
    tick(1);
    cmp("vnum_nmi", 1, vnum);
    ivm_periph_model_inst.clear(40'h2);
    tick(1);
    cmp("cirq_off", 0, cirq);
    cmp("flag5_kept", 1, flag[5]);
    ivm_periph_model_inst.clear('1);
    @(posedge clk_i);
    gie <= 1'b1;
  endtask
  task automatic t_prio;
    ivm_periph_model_inst.pulse((40'h1 << 3) | (40'h1 << 17) | (40'h1 << 30));
    tick(1);
    cmp("vnum_first", 3, vnum);
    ivm_periph_model_inst.clear(40'h1 << 3);
    tick(1);
    cmp("vnum_next", 17, vnum);
    ivm_periph_model_inst.clear('1);
  endtask
  task automatic t_map;
    for (int n = 1; n < NUM_VEC; n++) begin
      @(posedge clk_i);
      big <= n[0];
      ivm_periph_model_inst.pulse(40'h1 << n);
      tick(1);
      cmp("vnum", n, vnum);
      cmp("vaddr", n[0] ? 2 * n : n, vaddr);
      ivm_periph_model_inst.clear(40'h1 << n);
    end
    ivm_periph_model_inst.pulse(40'h1);
    cmp("flag0", 0, flag[0]);
  endtask
  task automatic t_dec;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_i);
      addr <= DA[i];
      #1;
      cmp("sel", DS[i], sel);
      if (DS[i] == IVM_SEL_VPORT)
        cmp("vport_idx", DA[i][4:2], vidx);
    end
  endtask
  task automatic t_rev;
    rd_chk(ADDR_PART_REV, REV);
    @(posedge clk_i);
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    rd_chk(ADDR_PART_REV, REV);
    rd_chk(16'h2000, 8'h00);
    rd_chk(ADDR_PART_REV, REV);
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    {rstn_i, big, rd, wr} = '0;
    {en_wr, en_wd} = '0;
    gie  = 1'b1;
    addr = 16'h0000;
    errors = 0;
    checks_done = 0;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    tick(2);
    t_walk_hold();
    t_global();
    t_prio();
    t_map();
    t_dec();
    t_rev();
    end_sim();
  end
  // run needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    end_sim();
  end
endmodule // irq_vector_and_address_map_tb
`default_nettype wire
